// File: lvs_regs.vh
`ifndef LVS_REGS_VH
`define LVS_REGS_VH
// ----------------------------------------
// Port addresses
// ----------------------------------------
`define LVS_PORT_STATUS_MONO   16'h03ba
`define LVS_PORT_STATUS_COLOUR 16'h03da
`define LVS_PORT_MISC_WR       16'h03c2
`define LVS_PORT_MISC_RD       16'h03cc
`define LVS_PORT_SEQ_INDEX     16'h03c4
`define LVS_PORT_SEQ_DATA      16'h03c5
`define LVS_PORT_FEAT_RD       16'h03ca
// ----------------------------------------
// Reset values
// ----------------------------------------
`define LVS_MISC_RESET         8'h00
`define LVS_SEQ_INDEX_RESET    3'h0
`define LVS_SEQ_RESET_RESET    1'b0
`define LVS_FEAT_RESET         1'b0
// ----------------------------------------
// Field positions
// ----------------------------------------
`define LVS_MISC_VSYNC_POL     7
`define LVS_MISC_HSYNC_POL     6
`define LVS_MISC_PAGE_SEL      5
`define LVS_MISC_CLK_HI        3
`define LVS_MISC_CLK_LO        2
`define LVS_MISC_APERTURE_EN   1
`define LVS_MISC_IO_SEL        0
`define LVS_MISC_WR_MASK       8'hef
`define LVS_FEAT_VSYNC_CTRL    3
`define LVS_SEQ_RESET_BIT      1
`define LVS_SEQ_IDX_RESET_REG  3'h0
`define LVS_STATUS_RETRACE     3
`define LVS_STATUS_DISP_EN     0
// ----------------------------------------
// Dot clock selections
// ----------------------------------------
`define LVS_CLK_NARROW         2'h0
`define LVS_CLK_WIDE           2'h1
`define LVS_CLK_UNUSED         2'h2
`define LVS_CLK_RESERVED       2'h3
`endif

// File: lvs_feedback_mux.v
`include "lvs_regs.vh"
// Picks two of eight palette colour bits for status feedback
module lvs_feedback_mux (
    input  wire [7:0] palette_bits,
    input  wire [1:0] plane_sel,
    output reg  [1:0] feedback
);
    // Pair chosen by colour plane enable bits 5:4
    always @* begin
        case (plane_sel)
            2'h0:    feedback = {palette_bits[4], palette_bits[0]};
            2'h1:    feedback = {palette_bits[5], palette_bits[1]};
            2'h2:    feedback = {palette_bits[3], palette_bits[2]};
            2'h3:    feedback = {palette_bits[7], palette_bits[6]};
            default: feedback = 2'h0;
        endcase
    end
endmodule

// File: lvs_port_decode.v
`include "lvs_regs.vh"
// Decodes the I/O port address into register selects
module lvs_port_decode (
    input  wire [15:0] io_addr,
    output wire        hit_status,
    output wire        hit_misc_wr,
    output wire        hit_misc_rd,
    output wire        hit_seq_index,
    output wire        hit_seq_data,
    output wire        hit_feat_rd
);
    // Both mono and colour ranges always claimed
    assign hit_status    = (io_addr == `LVS_PORT_STATUS_MONO) ||
                           (io_addr == `LVS_PORT_STATUS_COLOUR);
    assign hit_misc_wr   = (io_addr == `LVS_PORT_MISC_WR);
    assign hit_misc_rd   = (io_addr == `LVS_PORT_MISC_RD);
    assign hit_seq_index = (io_addr == `LVS_PORT_SEQ_INDEX);
    assign hit_seq_data  = (io_addr == `LVS_PORT_SEQ_DATA);
    assign hit_feat_rd   = (io_addr == `LVS_PORT_FEAT_RD);
endmodule

// File: lvs_status_ctrl.v
`include "lvs_regs.vh"
// Behaviour
// - Status bit 3 shows vertical retrace
// - Retrace status live from assigned pipe
// - Status bit 0 high during any blanking
// - Display enable live from assigned pipe
// - No interrupts from legacy bits
// - Status bits 5:4 from selected palette bits
// - Status bits 7, 6, 2:1 read zero
// - Feature write 3BA/3DA, read 3CA
// - Feature bit 3 stored, no effect
// - Feature bits 0,1 and reserved read zero
// - Misc output write 3C2, read 3CC
// - Misc bits 7:6 give sync polarity in native mode
// - Misc bit 5 picks odd/even page when odd_even_map set
// - Misc bits 3:2 pick dot clock in native mode, else narrow
// - Misc bit 1 gates legacy aperture
// - Misc bit 0 drives colour_emulation, not the range decode
// - Both port ranges always decoded
// - Index bits 2:0, data port 3C5
// - Sequencer index 0 holds reset bit 1, drives seq_reset_compat
// - Status read at 3BA or 3DA
module lvs_status_ctrl (
    input  wire        sys_clk,
    input  wire        rst_n,
    input  wire [15:0] io_addr,
    input  wire [15:0] io_wdata,
    input  wire [1:0]  io_byte_en,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire        pipe_vretrace,
    input  wire        pipe_hblank,
    input  wire        pipe_vblank,
    input  wire [7:0]  palette_bits,
    input  wire [7:0]  color_plane_enable_reg,
    input  wire        legacy_native_mode,
    input  wire        odd_even_map,
    output reg  [15:0] io_rdata,
    output reg         io_rd_valid,
    output reg         vsync_neg,
    output reg         hsync_neg,
    output reg         cpu_page_lower,
    output reg  [1:0]  dot_clock_sel,
    output reg         aperture_en,
    output reg         colour_emulation,
    output reg         seq_reset_compat,
    output reg  [2:0]  seq_index
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    reg  [7:0]  misc_output_ctrl;
    reg  [2:0]  sequencer_index_sel;
    reg         sequencer_reset_legacy;
    reg         feature_ctrl;
    reg  [7:0]  retrace_input_status;
    wire [1:0]  feedback;
    wire        hit_status;
    wire        hit_misc_wr;
    wire        hit_misc_rd;
    wire        hit_seq_index;
    wire        hit_seq_data;
    wire        hit_feat_rd;
    wire        hit_status_hi;
    wire        hit_misc_rd_hi;
    wire        hit_seq_data_hi;
    wire [15:0] addr_hi;
    reg  [7:0]  lo_byte;
    reg  [7:0]  hi_byte;
    reg  [7:0]  next_misc;
    reg  [2:0]  next_index;
    reg         next_seq_reset;
    reg         next_feature;

    assign addr_hi = io_addr + 16'h0001;

    // ----------------------------------------
    // Port decode, low byte and high byte lanes
    // ----------------------------------------
    lvs_port_decode u_dec_lo (
        .io_addr       (io_addr),
        .hit_status    (hit_status),
        .hit_misc_wr   (hit_misc_wr),
        .hit_misc_rd   (hit_misc_rd),
        .hit_seq_index (hit_seq_index),
        .hit_seq_data  (hit_seq_data),
        .hit_feat_rd   (hit_feat_rd)
    );

    lvs_port_decode u_dec_hi (
        .io_addr       (addr_hi),
        .hit_status    (hit_status_hi),
        .hit_misc_wr   (),
        .hit_misc_rd   (hit_misc_rd_hi),
        .hit_seq_index (),
        .hit_seq_data  (hit_seq_data_hi),
        .hit_feat_rd   ()
    );

    // Palette colour feedback selection
    lvs_feedback_mux u_fb (
        .palette_bits (palette_bits),
        .plane_sel    (color_plane_enable_reg[5:4]),
        .feedback     (feedback)
    );

    // ----------------------------------------
    // Live status; no interrupt path exists
    // ----------------------------------------
    always @* begin
        retrace_input_status = 8'h00;
        retrace_input_status[`LVS_STATUS_RETRACE] = pipe_vretrace;
        retrace_input_status[5:4] = feedback;
        retrace_input_status[`LVS_STATUS_DISP_EN] = pipe_hblank | pipe_vblank;
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    always @* begin
        next_misc      = misc_output_ctrl;
        next_index     = sequencer_index_sel;
        next_seq_reset = sequencer_reset_legacy;
        next_feature   = feature_ctrl;
        if (io_wr && io_byte_en[0]) begin
            if (hit_misc_wr)
                next_misc = io_wdata[7:0] & `LVS_MISC_WR_MASK;
            if (hit_seq_index)
                next_index = io_wdata[2:0];
            if (hit_seq_data && sequencer_index_sel == `LVS_SEQ_IDX_RESET_REG)
                next_seq_reset = io_wdata[`LVS_SEQ_RESET_BIT];
            if (hit_status)
                next_feature = io_wdata[`LVS_FEAT_VSYNC_CTRL];
        end
        // Word write to index port carries data in high lane
        if (io_wr && io_byte_en[1] && hit_seq_index &&
            ((io_byte_en[0] ? io_wdata[2:0] : sequencer_index_sel) ==
             `LVS_SEQ_IDX_RESET_REG))
            next_seq_reset = io_wdata[8 + `LVS_SEQ_RESET_BIT];
    end

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            misc_output_ctrl       <= `LVS_MISC_RESET;
            sequencer_index_sel    <= `LVS_SEQ_INDEX_RESET;
            sequencer_reset_legacy <= `LVS_SEQ_RESET_RESET;
            feature_ctrl           <= `LVS_FEAT_RESET;
        end else begin
            misc_output_ctrl       <= next_misc;
            sequencer_index_sel    <= next_index;
            sequencer_reset_legacy <= next_seq_reset;
            feature_ctrl           <= next_feature;
        end
    end

    // ----------------------------------------
    // Read byte selection
    // ----------------------------------------
    always @* begin
        lo_byte = 8'h00;
        hi_byte = 8'h00;
        if (hit_status)
            lo_byte = retrace_input_status;
        else if (hit_misc_rd)
            lo_byte = misc_output_ctrl;
        else if (hit_feat_rd)
            lo_byte = {4'h0, feature_ctrl, 3'h0};
        else if (hit_seq_index)
            lo_byte = {5'h00, sequencer_index_sel};
        else if (hit_seq_data && sequencer_index_sel == `LVS_SEQ_IDX_RESET_REG)
            lo_byte = {6'h00, sequencer_reset_legacy, 1'b0};
        if (hit_seq_data_hi && sequencer_index_sel == `LVS_SEQ_IDX_RESET_REG)
            hi_byte = {6'h00, sequencer_reset_legacy, 1'b0};
        else if (hit_status_hi)
            hi_byte = retrace_input_status;
        else if (hit_misc_rd_hi)
            hi_byte = misc_output_ctrl;
    end

    // ----------------------------------------
    // Registered read answer
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            io_rdata    <= 16'h0000;
            io_rd_valid <= 1'b0;
        end else begin
            io_rd_valid <= io_rd;
            if (io_rd)
                io_rdata <= {io_byte_en[1] ? hi_byte : 8'h00,
                             io_byte_en[0] ? lo_byte : 8'h00};
        end
    end

    // ----------------------------------------
    // Control outputs registered from next field values, on the same edge as the store
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            vsync_neg        <= 1'b0;
            hsync_neg        <= 1'b0;
            cpu_page_lower   <= 1'b0;
            dot_clock_sel    <= `LVS_CLK_NARROW;
            aperture_en      <= 1'b0;
            colour_emulation <= 1'b0;
            seq_reset_compat <= 1'b0;
            seq_index        <= 3'h0;
        end else begin
            vsync_neg        <= legacy_native_mode & next_misc[`LVS_MISC_VSYNC_POL];
            hsync_neg        <= legacy_native_mode & next_misc[`LVS_MISC_HSYNC_POL];
            cpu_page_lower   <= odd_even_map & next_misc[`LVS_MISC_PAGE_SEL];
            dot_clock_sel    <= legacy_native_mode ?
                                next_misc[`LVS_MISC_CLK_HI:`LVS_MISC_CLK_LO] :
                                `LVS_CLK_NARROW;
            aperture_en      <= next_misc[`LVS_MISC_APERTURE_EN];
            colour_emulation <= next_misc[`LVS_MISC_IO_SEL];
            seq_reset_compat <= next_seq_reset;
            seq_index        <= next_index;
        end
    end
endmodule

// File: lvs_status_ctrl_chk.sv
`include "lvs_regs.vh"
module lvs_chk (
    input wire logic        sys_clk,
    input wire logic        rst_n,
    input wire logic [15:0] io_addr,
    input wire logic [15:0] io_wdata,
    input wire logic [1:0]  io_byte_en,
    input wire logic        io_wr,
    input wire logic        io_rd,
    input wire logic        pipe_vretrace,
    input wire logic        pipe_hblank,
    input wire logic        pipe_vblank,
    input wire logic        legacy_native_mode,
    input wire logic        odd_even_map,
    input wire logic [15:0] io_rdata,
    input wire logic        io_rd_valid,
    input wire logic [1:0]  dot_clock_sel,
    input wire logic        aperture_en,
    input wire logic        colour_emulation,
    input wire logic        cpu_page_lower
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Access sequences
    // ----------------------------------------
    sequence misc_wr_s;
        io_wr && io_byte_en[0] && io_addr == `LVS_PORT_MISC_WR;
    endsequence
    sequence stat_rd_s;
        io_rd && io_byte_en[0] &&
        (io_addr == `LVS_PORT_STATUS_MONO || io_addr == `LVS_PORT_STATUS_COLOUR);
    endsequence
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    rd_answer_a: assert property (io_rd |=> io_rd_valid)
        else $error("read answer missing");
    no_answer_a: assert property (!io_rd |=> !io_rd_valid)
        else $error("spurious read answer");
    retrace_bit_a: assert property (stat_rd_s |=> io_rdata[3] == $past(pipe_vretrace))
        else $error("retrace bit wrong");
    blank_bit_a: assert property (stat_rd_s |=>
        io_rdata[0] == $past(pipe_hblank || pipe_vblank))
        else $error("blank bit wrong");
    stat_zero_a: assert property (stat_rd_s |=>
        io_rdata[7:6] == 2'h0 && io_rdata[2:1] == 2'h0)
        else $error("status zero bits set");
    aperture_upd_a: assert property (misc_wr_s |=> aperture_en == $past(io_wdata[1]))
        else $error("aperture enable not updated");
    io_sel_a: assert property (misc_wr_s |=> colour_emulation == $past(io_wdata[0]))
        else $error("range select not updated");
    dot_gate_a: assert property ((!legacy_native_mode)[*2] |-> dot_clock_sel == 2'h0)
        else $error("dot clock not forced");
    page_gate_a: assert property ((!odd_even_map)[*2] |-> !cpu_page_lower)
        else $error("page select not gated");
    rdata_hold_a: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data changed");
endmodule

bind lvs_status_ctrl lvs_chk u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_byte_en(io_byte_en), .io_wr(io_wr), .io_rd(io_rd),
    .pipe_vretrace(pipe_vretrace), .pipe_hblank(pipe_hblank), .pipe_vblank(pipe_vblank),
    .legacy_native_mode(legacy_native_mode), .odd_even_map(odd_even_map),
    .io_rdata(io_rdata), .io_rd_valid(io_rd_valid), .dot_clock_sel(dot_clock_sel),
    .aperture_en(aperture_en), .colour_emulation(colour_emulation),
    .cpu_page_lower(cpu_page_lower));

// File: lvs_status_ctrl_tb.sv
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module lvs_status_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [15:0] io_wdata = 16'h0000;
    logic [1:0]  io_byte_en = 2'h0;
    logic        io_wr = 1'b0;
    logic        io_rd = 1'b0;
    logic        vr = 1'b0, hb = 1'b0, vb = 1'b0, nat = 1'b0, oe = 1'b0;
    logic [7:0]  pal = 8'h00, cpe = 8'h00;
    wire  [15:0] io_rdata;
    wire  [1:0]  dcs;
    wire  [2:0]  sidx;
    wire         rdv, vsn, hsn, cpl, ape, cem, src;
    int          misc, feat, idx, sr0, failures = 0, n_compared = 0;
    integer      seed = 32'hee78b6d5;
    logic [15:0] last = 16'h0000;
    logic [15:0] exp_q [$];
    logic [15:0] ports [8] = '{16'h03ba, 16'h03da, 16'h03c2, 16'h03cc,
                               16'h03c4, 16'h03c5, 16'h03ca, 16'h03c0};
    // ----------------------------------------
    // Design and clock
    // ----------------------------------------
    lvs_status_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .io_addr(io_addr),
        .io_wdata(io_wdata), .io_byte_en(io_byte_en), .io_wr(io_wr), .io_rd(io_rd),
        .pipe_vretrace(vr), .pipe_hblank(hb), .pipe_vblank(vb), .palette_bits(pal),
        .color_plane_enable_reg(cpe), .legacy_native_mode(nat), .odd_even_map(oe),
        .io_rdata(io_rdata), .io_rd_valid(rdv), .vsync_neg(vsn), .hsync_neg(hsn),
        .cpu_page_lower(cpl), .dot_clock_sel(dcs), .aperture_en(ape),
        .colour_emulation(cem), .seq_reset_compat(src), .seq_index(sidx));
    initial begin
        forever #5 sys_clk = ~sys_clk;
    end
    // ----------------------------------------
    // Register model
    // ----------------------------------------
    function automatic logic [7:0] exp_byte(input logic [15:0] a);
        logic [1:0] fb;
        case (cpe[5:4])
            2'h0: fb = {pal[4], pal[0]};
            2'h1: fb = {pal[5], pal[1]};
            2'h2: fb = {pal[3], pal[2]};
            default: fb = {pal[7], pal[6]};
        endcase
        case (a)
            16'h03ba, 16'h03da: exp_byte = {2'h0, fb, vr, 2'h0, hb | vb};
            16'h03c4: exp_byte = {5'h00, idx[2:0]};
            16'h03c5: exp_byte = (idx == 0) ? {6'h00, sr0[0], 1'b0} : 8'h00;
            16'h03ca: exp_byte = {4'h0, feat[0], 3'h0};
            16'h03cc: exp_byte = misc[7:0];
            default: exp_byte = 8'h00;
        endcase
    endfunction
    task automatic upd(input logic [15:0] a, input logic [7:0] d);
        case (a)
            16'h03ba, 16'h03da: feat = d[3];
            16'h03c2: misc = d & 8'hef;
            16'h03c4: idx = d[2:0];
            16'h03c5: if (idx == 0) sr0 = d[1];
            default: ;
        endcase
    endtask
    // One access: strobe for one edge, then compare answer and controls
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       input logic [1:0] be);
        logic [31:0] r;
        r = $random(seed);
        @(negedge sys_clk);
        {vr, hb, vb, nat, oe} = r[4:0];
        pal = r[15:8];
        cpe = r[23:16];
        io_addr = a;
        io_wdata = d;
        io_byte_en = be;
        io_wr = wr;
        io_rd = !wr;
        if (!wr) exp_q.push_back({be[1] ? exp_byte(a + 16'h1) : 8'h00,
                                  be[0] ? exp_byte(a) : 8'h00});
        if (wr && be[0]) upd(a, d[7:0]);
        if (wr && be[1]) upd(a + 16'h1, d[15:8]);
        @(negedge sys_clk);
        io_wr = 1'b0;
        io_rd = 1'b0;
        if (exp_q.size() != 0) last = exp_q.pop_front();
        `CHK("rd_valid", !wr, rdv)
        `CHK("rdata", last, io_rdata)
        `CHK("ctrl", {misc[7] & nat, misc[6] & nat, misc[5] & oe, nat ? misc[3:2] : 2'h0,
            misc[1:0], sr0[0], idx[2:0]},
            {vsn, hsn, cpl, dcs, ape, cem, src, sidx})
    endtask
    task automatic reset_and_read();
        rst_n = 1'b0;
        {misc, feat, idx, sr0} = {32'h0, 32'h0, 32'h0, 32'h0};
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        foreach (ports[i]) acc(1'b0, ports[i], 16'h0000, 2'h1);
    endtask
    task automatic summarize();
        if (failures == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        logic [31:0] r;
        logic [15:0] a;
        reset_and_read();
        acc(1'b1, 16'h03c4, 16'h0200, 2'h3);
        acc(1'b0, 16'h03c4, 16'h0000, 2'h3);
        repeat (600) begin
            r = $random(seed);
            a = ports[r[2:0]];
            acc(r[3], a, r[31:16], (!a[0] && r[4]) ? 2'h3 : 2'h1);
        end
        reset_and_read();
        summarize();
    end
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule
